/* File: rtl/jtx_defs.vh */
// Constants for the serial converter output transport and link block.
`ifndef JTX_DEFS_VH
`define JTX_DEFS_VH
// ============================================================
// Register word addresses (bus address bits 7:2)
`define JTX_ADR_CTRL 6'h00
`define JTX_ADR_FORMAT 6'h01
`define JTX_ADR_TEST 6'h02
`define JTX_ADR_STATUS 6'h03
// ============================================================
// Control register fields
`define JTX_CTRL_SCR 0
`define JTX_CTRL_SEQ_DIS 1
`define JTX_CTRL_FRAME_AL 2
`define JTX_CTRL_LANE_AL 3
`define JTX_CTRL_SYNC_REQ 4
`define JTX_CTRL_REL_HI 6
`define JTX_CTRL_REL_LO 5
`define JTX_CTRL_RESET 32'h0000000C
// ============================================================
// Format register fields
`define JTX_FMT_CPL_HI 1
`define JTX_FMT_CPL_LO 0
`define JTX_FMT_RES_HI 3
`define JTX_FMT_RES_LO 2
`define JTX_FMT_PD_HI 15
`define JTX_FMT_PD_LO 8
`define JTX_FMT_K_HI 20
`define JTX_FMT_K_LO 16
`define JTX_FMT_RESET 32'h00070006
// ============================================================
// Test register fields and modes
`define JTX_TST_MODE_HI 1
`define JTX_TST_MODE_LO 0
`define JTX_TST_VAL_HI 31
`define JTX_TST_VAL_LO 16
`define JTX_TST_RESET 32'h00000000
`define JTX_TST_OFF 2'h0
`define JTX_TST_CONST 2'h1
`define JTX_TST_RAMP 2'h2
// ============================================================
// Link states and characters
`define JTX_ST_CGS 2'h0
`define JTX_ST_ILA 2'h1
`define JTX_ST_DATA 2'h2
`define JTX_K28_0 8'h1C
`define JTX_K28_3 8'h7C
`define JTX_K28_4 8'h9C
`define JTX_K28_5 8'hBC
`define JTX_K28_7 8'hFC
`define JTX_SYNC_MIN 3'h4
`define JTX_ILA_LAST_MF 2'h3
`endif

/* File: rtl/jtx_link_tx.v */
// Transmit transport and link layer for one serial lane.
//
// Operation
// - Eight converters: two octets each, left-justified, sixteen octets.
// - Four converters use eight octets; two use four.
// - Tail bits are driven zero for converter samples; test patterns are sent unmasked.
// - Powered-down converter slot carries all zeros.
// - Exactly one sample per converter per frame.
// - Selected test pattern replaces converter sample data.
// - Standard scrambler runs only when enabled.
// - Scrambler bypassed during sync and alignment sequence.
// - Octets 8b/10b encoded, most significant bit first.
// - Sync state sends repeated K28.5 characters.
// - Sync entered on a low pulse of four clocks or more, or on software request.
// - Software sync request also forces K28.5 stream.
// - Alignment sequence follows sync unless disabled.
// - Leave sync on multiframe boundary after release.
// - Release delay postpones start by 0-3 boundaries.
// - No alignment insertion means no character replacement.
// - Unscrambled repeated multiframe end becomes K28.3.
// - Unscrambled repeated frame end becomes K28.7 unless the previous frame ended in a control character.
// - Scrambled multiframe end D28.3 becomes K28.3.
// - Scrambled frame end D28.7 becomes K28.7.
// - Both insertions apply together per scrambling mode.
`timescale 1ns/1ns
`include "jtx_defs.vh"
module jtx_link_tx #(
    parameter NUM_CONV = 8,
    parameter SAMPLE_W = 16
) (
    input wire clk_in,
    input wire rst_n_in,
    input wire wb_cyc_in,
    input wire wb_stb_in,
    input wire wb_we_in,
    input wire [7:0] wb_adr_in,
    input wire [3:0] wb_sel_in,
    input wire [31:0] wb_dat_in,
    output reg [31:0] wb_dat_out,
    output reg wb_ack_out,
    input wire [NUM_CONV*SAMPLE_W-1:0] sample_data_in,
    input wire sync_n_in,
    output reg [9:0] lane_code_out,
    output reg frame_take_out,
    output reg [1:0] link_state_out
);
    localparam FW = NUM_CONV * SAMPLE_W;

    // ============================================================
    // Helper functions
    function [31:0] jtx_merge;
        input [31:0] old_v;
        input [31:0] new_v;
        input [3:0] sel;
        integer b;
        begin
            jtx_merge = old_v;
            for (b = 0; b < 4; b = b + 1) begin
                if (sel[b]) begin
                    jtx_merge[8*b +: 8] = new_v[8*b +: 8];
                end
            end
        end
    endfunction

    function [2:0] jtx_ones;
        input [5:0] v;
        integer b;
        begin
            jtx_ones = 3'h0;
            for (b = 0; b < 6; b = b + 1) begin
                jtx_ones = jtx_ones + {2'h0, v[b]};
            end
        end
    endfunction

    // Self-synchronous 1 + x^14 + x^15, MSB first; returns {state, octet}.
    function [22:0] jtx_scramble;
        input [7:0] d;
        input [14:0] s;
        integer b;
        reg [14:0] st;
        reg [7:0] o;
        begin
            st = s;
            o = 8'h00;
            for (b = 7; b >= 0; b = b - 1) begin
                o[b] = d[b] ^ st[13] ^ st[14];
                st = {st[13:0], o[b]};
            end
            jtx_scramble = {st, o};
        end
    endfunction

    // 8b/10b encoder; returns {new disparity, abcdei fghj}.
    function [10:0] jtx_encode;
        input [7:0] d;
        input k;
        input rd;
        reg [5:0] c6;
        reg [3:0] c4;
        reg rd6;
        reg a7;
        begin
            case (d[4:0])
            5'h00: c6 = 6'h27; 5'h01: c6 = 6'h1D; 5'h02: c6 = 6'h2D;
            5'h03: c6 = 6'h31; 5'h04: c6 = 6'h35; 5'h05: c6 = 6'h29;
            5'h06: c6 = 6'h19; 5'h07: c6 = 6'h38; 5'h08: c6 = 6'h39;
            5'h09: c6 = 6'h25; 5'h0A: c6 = 6'h15; 5'h0B: c6 = 6'h34;
            5'h0C: c6 = 6'h0D; 5'h0D: c6 = 6'h2C; 5'h0E: c6 = 6'h1C;
            5'h0F: c6 = 6'h17; 5'h10: c6 = 6'h1B; 5'h11: c6 = 6'h23;
            5'h12: c6 = 6'h13; 5'h13: c6 = 6'h32; 5'h14: c6 = 6'h0B;
            5'h15: c6 = 6'h2A; 5'h16: c6 = 6'h1A; 5'h17: c6 = 6'h3A;
            5'h18: c6 = 6'h33; 5'h19: c6 = 6'h26; 5'h1A: c6 = 6'h16;
            5'h1B: c6 = 6'h36; 5'h1C: c6 = 6'h0E; 5'h1D: c6 = 6'h2E;
            5'h1E: c6 = 6'h1E; default: c6 = 6'h2B;
            endcase
            if (k) begin
                c6 = 6'h0F;
            end
            if (rd && ((jtx_ones(c6) != 3'h3) || (c6 == 6'h38))) begin
                c6 = ~c6;
            end
            rd6 = (jtx_ones(c6) == 3'h3) ? rd : (jtx_ones(c6) > 3'h3);
            a7 = k || (!rd6 && (d[4:0] == 5'h11 || d[4:0] == 5'h12 ||
                 d[4:0] == 5'h14)) || (rd6 && (d[4:0] == 5'h0B ||
                 d[4:0] == 5'h0D || d[4:0] == 5'h0E));
            case (d[7:5])
            3'h0: c4 = 4'hB; 3'h1: c4 = 4'h9; 3'h2: c4 = 4'h5;
            3'h3: c4 = 4'hC; 3'h4: c4 = 4'hD; 3'h5: c4 = 4'hA;
            3'h6: c4 = 4'h6; default: c4 = a7 ? 4'h7 : 4'hE;
            endcase
            if (rd6 && ((jtx_ones({2'h0, c4}) != 3'h2) || (c4 == 4'hC))) begin
                c4 = ~c4;
            end
            if (k && !rd6 && jtx_ones({2'h0, c4}) == 3'h2 && c4 != 4'hC) begin
                c4 = ~c4;
            end
            jtx_encode = {(jtx_ones({2'h0, c4}) == 3'h2) ? rd6 :
                          (jtx_ones({2'h0, c4}) > 3'h2), c6, c4};
        end
    endfunction

    // ============================================================
    // Register file
    reg [31:0] ctrl_r;
    reg [31:0] format_r;
    reg [31:0] test_r;
    reg [1:0] state_r;
    wire wb_req = wb_cyc_in && wb_stb_in && !wb_ack_out;
    wire [5:0] wb_word = wb_adr_in[7:2];

    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            ctrl_r <= `JTX_CTRL_RESET;
            format_r <= `JTX_FMT_RESET;
            test_r <= `JTX_TST_RESET;
            wb_ack_out <= 1'b0;
            wb_dat_out <= 32'h00000000;
        end else begin
            wb_ack_out <= wb_req;
            if (wb_req && wb_we_in) begin
                case (wb_word)
                `JTX_ADR_CTRL: begin
                    ctrl_r <= jtx_merge(ctrl_r, wb_dat_in, wb_sel_in) &
                              32'h0000007F;
                end
                `JTX_ADR_FORMAT: begin
                    format_r <= jtx_merge(format_r, wb_dat_in, wb_sel_in) &
                                32'h001FFF0F;
                end
                `JTX_ADR_TEST: begin
                    test_r <= jtx_merge(test_r, wb_dat_in, wb_sel_in) &
                              32'hFFFF0003;
                end
                default: begin
                end
                endcase
            end
            if (wb_req && !wb_we_in) begin
                case (wb_word)
                `JTX_ADR_CTRL: wb_dat_out <= ctrl_r;
                `JTX_ADR_FORMAT: wb_dat_out <= format_r;
                `JTX_ADR_TEST: wb_dat_out <= test_r;
                `JTX_ADR_STATUS: begin
                    wb_dat_out <= {29'h00000000, sync_n_in, state_r};
                end
                default: wb_dat_out <= 32'h00000000;
                endcase
            end
        end
    end

    wire scrambler_enable = ctrl_r[`JTX_CTRL_SCR];
    wire seq_dis = ctrl_r[`JTX_CTRL_SEQ_DIS];
    wire frame_al = ctrl_r[`JTX_CTRL_FRAME_AL];
    wire lane_al = ctrl_r[`JTX_CTRL_LANE_AL];
    wire sync_req = ctrl_r[`JTX_CTRL_SYNC_REQ];
    wire [1:0] rel_delay = ctrl_r[`JTX_CTRL_REL_HI:`JTX_CTRL_REL_LO];
    wire [1:0] cpl_code = format_r[`JTX_FMT_CPL_HI:`JTX_FMT_CPL_LO];
    wire [1:0] res_code = format_r[`JTX_FMT_RES_HI:`JTX_FMT_RES_LO];
    wire [7:0] pd_mask = format_r[`JTX_FMT_PD_HI:`JTX_FMT_PD_LO];
    wire [4:0] k_last = format_r[`JTX_FMT_K_HI:`JTX_FMT_K_LO];
    wire [1:0] tst_mode = test_r[`JTX_TST_MODE_HI:`JTX_TST_MODE_LO];
    wire [15:0] tst_val = test_r[`JTX_TST_VAL_HI:`JTX_TST_VAL_LO];

    // ============================================================
    // Transport layer: one frame is built per frame period
    reg [FW-1:0] frame_r;
    reg [15:0] ramp_r;
    wire [FW-1:0] build_w;
    // Resolution 10/12/14/16 moves the low sample bits to the top; the rest are tail zeros.
    wire [15:0] res_mask = 16'hFFFF << (6 - {res_code, 1'b0});
    genvar gi;
    generate
        for (gi = 0; gi < NUM_CONV; gi = gi + 1) begin : g_conv
            wire [15:0] raw = sample_data_in[FW-1-SAMPLE_W*gi -: SAMPLE_W];
            wire [15:0] just = (raw << (6 - {res_code, 1'b0})) & res_mask;
            wire [15:0] pick = (tst_mode == `JTX_TST_CONST) ? tst_val :
                               (tst_mode == `JTX_TST_RAMP) ? ramp_r :
                               just;
            assign build_w[FW-1-SAMPLE_W*gi -: SAMPLE_W] =
                pd_mask[gi] ? 16'h0000 : pick;
        end
    endgenerate

    reg [3:0] oct_r;
    reg [4:0] frm_r;
    reg [1:0] ila_mf_r;
    // Frame length is two octets per converter on the lane.
    wire [3:0] oct_last = (cpl_code == 2'h0) ? 4'h3 :
                          (cpl_code == 2'h1) ? 4'h7 : 4'hF;
    wire frame_end = (oct_r == oct_last);
    wire mf_end = frame_end && (frm_r == k_last);
    wire [7:0] data_oct = frame_r[FW-1-8*oct_r -: 8];

    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            frame_r <= {FW{1'b0}};
            ramp_r <= 16'h0000;
            oct_r <= 4'h0;
            frm_r <= 5'h00;
            frame_take_out <= 1'b0;
        end else begin
            frame_take_out <= frame_end;
            oct_r <= frame_end ? 4'h0 : oct_r + 4'h1;
            if (frame_end) begin
                frm_r <= mf_end ? 5'h00 : frm_r + 5'h01;
                frame_r <= build_w;
                ramp_r <= ramp_r + 16'h0001;
            end
        end
    end

    // ============================================================
    // Link state machine
    reg [2:0] low_cnt_r;
    reg [1:0] edge_cnt_r;
    reg [1:0] state_nxt;
    wire sync_pulse = !sync_n_in && (low_cnt_r >= `JTX_SYNC_MIN - 3'h1);

    always @* begin
        state_nxt = state_r;
        case (state_r)
        `JTX_ST_CGS: begin
            if (sync_n_in && !sync_req && mf_end &&
                edge_cnt_r == rel_delay) begin
                state_nxt = seq_dis ? `JTX_ST_DATA : `JTX_ST_ILA;
            end
        end
        `JTX_ST_ILA: begin
            if (mf_end && ila_mf_r == `JTX_ILA_LAST_MF) begin
                state_nxt = `JTX_ST_DATA;
            end
        end
        `JTX_ST_DATA: state_nxt = `JTX_ST_DATA;
        default: state_nxt = `JTX_ST_CGS;
        endcase
        if (sync_pulse || sync_req) begin
            state_nxt = `JTX_ST_CGS;
        end
    end

    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            state_r <= `JTX_ST_CGS;
            low_cnt_r <= 3'h0;
            edge_cnt_r <= 2'h0;
            ila_mf_r <= 2'h0;
            link_state_out <= `JTX_ST_CGS;
        end else begin
            state_r <= state_nxt;
            link_state_out <= state_nxt;
            if (sync_n_in) begin
                low_cnt_r <= 3'h0;
            end else if (low_cnt_r != `JTX_SYNC_MIN) begin
                low_cnt_r <= low_cnt_r + 3'h1;
            end
            if (state_r != `JTX_ST_CGS || !sync_n_in || sync_req) begin
                edge_cnt_r <= 2'h0;
            end else if (mf_end && edge_cnt_r != rel_delay) begin
                edge_cnt_r <= edge_cnt_r + 2'h1;
            end
            if (state_r != `JTX_ST_ILA) begin
                ila_mf_r <= 2'h0;
            end else if (mf_end) begin
                ila_mf_r <= ila_mf_r + 2'h1;
            end
        end
    end

    // ============================================================
    // Scrambling, alignment characters and encoding
    reg [14:0] scr_r;
    reg rd_r;
    reg [7:0] prev_frame_r;
    reg [7:0] prev_mf_r;
    reg prev_align_r;
    reg [7:0] out_oct;
    reg out_k;
    reg lane_hit;
    reg frame_hit;
    wire [22:0] scr_w = jtx_scramble(data_oct, scr_r);
    wire [7:0] link_oct = scrambler_enable ? scr_w[7:0] : data_oct;
    wire [10:0] enc_w = jtx_encode(out_oct, out_k, rd_r);

    always @* begin
        out_oct = link_oct;
        out_k = 1'b0;
        lane_hit = 1'b0;
        frame_hit = 1'b0;
        if (scrambler_enable) begin
            lane_hit = lane_al && mf_end && link_oct == `JTX_K28_3;
            frame_hit = frame_al && frame_end &&
                        link_oct == `JTX_K28_7;
        end else begin
            lane_hit = lane_al && mf_end && data_oct == prev_mf_r;
            frame_hit = frame_al && frame_end && !prev_align_r &&
                        data_oct == prev_frame_r;
        end
        if (lane_hit) begin
            out_k = 1'b1;
            out_oct = `JTX_K28_3;
        end else if (frame_hit) begin
            out_k = 1'b1;
            out_oct = `JTX_K28_7;
        end
        if (state_r == `JTX_ST_CGS) begin
            out_k = 1'b1;
            out_oct = `JTX_K28_5;
        end else if (state_r == `JTX_ST_ILA) begin
            // Sequence payload is a plain octet ramp; no config fields.
            out_k = 1'b0;
            out_oct = {4'h0, oct_r};
            if (oct_r == 4'h0 && frm_r == 5'h00) begin
                out_k = 1'b1;
                out_oct = `JTX_K28_0;
            end else if (oct_r == 4'h1 && frm_r == 5'h00 &&
                         ila_mf_r == 2'h1) begin
                out_k = 1'b1;
                out_oct = `JTX_K28_4;
            end else if (mf_end) begin
                out_k = 1'b1;
                out_oct = `JTX_K28_3;
            end
        end
    end

    always @(posedge clk_in) begin
        if (!rst_n_in) begin
            scr_r <= 15'h0000;
            rd_r <= 1'b0;
            prev_frame_r <= 8'h00;
            prev_mf_r <= 8'h00;
            prev_align_r <= 1'b0;
            lane_code_out <= 10'h000;
        end else begin
            // The scrambler state only advances on user data.
            if (state_r == `JTX_ST_DATA && scrambler_enable) begin
                scr_r <= scr_w[22:8];
            end
            rd_r <= enc_w[10];
            lane_code_out <= enc_w[9:0];
            if (frame_end) begin
                prev_frame_r <= data_oct;
                prev_align_r <= out_k;
            end
            if (mf_end) begin
                prev_mf_r <= data_oct;
            end
        end
    end
endmodule

/* File: testbench/jtx_link_tx_assertions.sv */
// Concurrent checks on the ports of the transmit lane block.
`timescale 1ns/1ns
module jtx_link_tx_assertions #(
    parameter NUM_CONV = 8,
    parameter SAMPLE_W = 16
) (
    input wire clk_in,
    input wire rst_n_in,
    input wire wb_cyc_in,
    input wire wb_stb_in,
    input wire wb_we_in,
    input wire [7:0] wb_adr_in,
    input wire [3:0] wb_sel_in,
    input wire [31:0] wb_dat_in,
    input wire [31:0] wb_dat_out,
    input wire wb_ack_out,
    input wire [NUM_CONV*SAMPLE_W-1:0] sample_data_in,
    input wire sync_n_in,
    input wire [9:0] lane_code_out,
    input wire frame_take_out,
    input wire [1:0] link_state_out
);
    // ==========================================================
    // Bus and link checks
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);
    ack_pulse_a: assert property (wb_ack_out |=> !wb_ack_out)
        else $error("bus acknowledge held past one cycle");
    ack_answer_a: assert property (
        wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
        else $error("bus request not answered on the next edge");
    unmapped_zero_a: assert property (wb_cyc_in && wb_stb_in && !wb_we_in
        && !wb_ack_out && wb_adr_in[7:4] != 4'h0 |=> wb_dat_out == 32'h0)
        else $error("unmapped read returned nonzero data");
    sync_entry_a: assert property (
        !sync_n_in [*4] |=> link_state_out == 2'h0)
        else $error("long sync request did not enter sync state");
    cgs_comma_a: assert property (
        $past(rst_n_in) && link_state_out == 2'h0 ##1
        link_state_out == 2'h0 |-> lane_code_out inside
        {10'h0FA, 10'h305}) else $error("sync state sent a non comma");
    disp_flip_a: assert property (
        lane_code_out inside {10'h0FA, 10'h305}
        |=> lane_code_out != $past(lane_code_out))
        else $error("running disparity did not flip after comma");
    leave_sync_a: assert property (
        $past(link_state_out) == 2'h0 && link_state_out != 2'h0
        |-> $past(sync_n_in)) else $error("left sync state while held");
    ila_entry_a: assert property (
        $rose(link_state_out == 2'h1) |-> $past(link_state_out) == 2'h0)
        else $error("alignment sequence entered from wrong state");
    ila_span_a: assert property (
        $rose(link_state_out == 2'h1) |-> link_state_out == 2'h1 [*8])
        else $error("alignment sequence cut short");
    take_pulse_a: assert property (frame_take_out |=> !frame_take_out)
        else $error("frame take pulse longer than one cycle");
    cover property (link_state_out == 2'h1);
    cover property (lane_code_out == 10'h0F3);
    cover property (!sync_n_in [*4]);
endmodule
bind jtx_link_tx jtx_link_tx_assertions #(.NUM_CONV(NUM_CONV),
    .SAMPLE_W(SAMPLE_W)) u_chk (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in),
    .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in),
    .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
    .sample_data_in(sample_data_in), .sync_n_in(sync_n_in),
    .lane_code_out(lane_code_out), .frame_take_out(frame_take_out),
    .link_state_out(link_state_out));

/* File: testbench/jtx_rx_model.sv */
// Far-end receiver model that drives the sync request line.
`timescale 1ns/1ns
module jtx_rx_model (
    input wire clk_in,
    input wire go_in,
    input wire [3:0] len_in,
    output reg sync_n_out
);
    reg [3:0] left_r;
    initial begin
        sync_n_out = 1'h1;
        left_r = 4'h0;
    end
    // A request lasts len_in edges; short ones test the width filter.
    always @(posedge clk_in) begin
        if (go_in) begin
            sync_n_out <= 1'h0;
            left_r <= len_in - 4'h1;
        end else if (left_r != 4'h0) begin
            left_r <= left_r - 4'h1;
        end else begin
            sync_n_out <= 1'h1;
        end
    end
endmodule

/* File: testbench/jtx_link_tx_tb_top.sv */
// Self-checking bench for the transmit lane block.
`timescale 1ns/1ns
module jtx_link_tx_tb_top;
    reg clk_in, rst_n_in, wb_cyc_in, wb_stb_in, wb_we_in, go;
    reg [7:0] wb_adr_in;
    reg [31:0] wb_dat_in, q;
    reg [127:0] sample_data_in;
    reg [3:0] len;
    wire [31:0] wb_dat_out;
    wire wb_ack_out, sync_n, frame_take_out;
    wire [9:0] lane_code_out;
    wire [1:0] link_state_out;
    integer n_errors, cmp_count, h, t, i;
    jtx_link_tx DUT (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in),
        .wb_adr_in(wb_adr_in), .wb_sel_in(4'hF), .wb_dat_in(wb_dat_in),
        .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
        .sample_data_in(sample_data_in), .sync_n_in(sync_n),
        .lane_code_out(lane_code_out), .frame_take_out(frame_take_out),
        .link_state_out(link_state_out));
    jtx_rx_model u_rx (.clk_in(clk_in), .go_in(go), .len_in(len),
        .sync_n_out(sync_n));
    // ==========================================================
    // Shared tasks
    task cmp(input [31:0] e, input [31:0] g, input string w);
        begin
            cmp_count = cmp_count + 1;
            if (g !== e) begin
                n_errors = n_errors + 1;
                $display("unexpected %0s: expected %h, seen %h", w, e, g);
            end
        end
    endtask
    task wb(input we, input [7:0] a, input [31:0] d);
        begin
            t = 0;
            wb_cyc_in <= 1'h1;
            wb_stb_in <= 1'h1;
            wb_we_in <= we;
            wb_adr_in <= a;
            wb_dat_in <= d;
            @(posedge clk_in);
            while (wb_ack_out !== 1'h1 && t < 20) begin
                @(posedge clk_in);
                t = t + 1;
            end
            q = wb_dat_out;
            cmp(1, wb_ack_out, "ack");
            wb_cyc_in <= 1'h0;
            wb_stb_in <= 1'h0;
            @(posedge clk_in);
        end
    endtask
    task wait_st(input [1:0] s, input integer n);
        begin
            t = 0;
            while (link_state_out !== s && t < n) begin
                @(posedge clk_in);
                t = t + 1;
            end
            cmp(s, link_state_out, "link state");
        end
    endtask
    // Counts the symbols equal to either running-disparity form.
    task scan(input integer n, input [9:0] a, input [9:0] b);
        begin
            h = 0;
            for (i = 0; i < n; i = i + 1) begin
                @(posedge clk_in);
                if (lane_code_out === a || lane_code_out === b) h = h + 1;
            end
        end
    endtask
    task pulse(input [3:0] n);
        begin
            len <= n;
            go <= 1'h1;
            @(posedge clk_in);
            go <= 1'h0;
        end
    endtask
    task cfg(input [7:0] a, input [31:0] d);
        begin
            wb(1'h1, a, d);
            repeat (300) @(posedge clk_in);
        end
    endtask
    // ==========================================================
    // Scenarios
    task t_regs;
        begin
            wb(1'h0, 8'h00, 32'h0);
            cmp(32'h0000000C, q, "ctrl reset");
            wb(1'h0, 8'h04, 32'h0);
            cmp(32'h00070006, q, "format reset");
            wb(1'h0, 8'h08, 32'h0);
            cmp(32'h0, q, "test reset");
            wb(1'h1, 8'h40, 32'hFFFFFFFF);
            wb(1'h0, 8'h40, 32'h0);
            cmp(32'h0, q, "unmapped");
            wb(1'h1, 8'h04, 32'h0007000E);
            wb(1'h0, 8'h04, 32'h0);
            cmp(32'h0007000E, q, "format");
        end
    endtask
    task t_data;
        begin
            sample_data_in <= {8{16'hB54A}};
            cfg(8'h00, 32'h0);
            scan(256, 10'h2AA, 10'h155);
            cmp(256, h, "packed octets");
            sample_data_in <= 128'h0;
            cfg(8'h08, 32'hB54A0001);
            scan(256, 10'h2AA, 10'h155);
            cmp(256, h, "test pattern");
            cfg(8'h04, 32'h0007FF0E);
            scan(256, 10'h274, 10'h18B);
            cmp(256, h, "powered down");
            sample_data_in <= {8{16'h02D4}};
            wb(1'h1, 8'h08, 32'h0);
            cfg(8'h04, 32'h00070002);
            scan(256, 10'h274, 10'h18B);
            cmp(128, h, "tail zeros");
            for (i = 0; i < 3; i = i + 1) begin
                cfg(8'h04, 32'h0007000C | i);
                h = 0;
                repeat (256) @(posedge clk_in) h = h + frame_take_out;
                cmp(256 / (4 << i), h, "frames");
            end
        end
    endtask
    task t_align;
        begin
            wb(1'h1, 8'h08, 32'hB54A0001);
            cfg(8'h00, 32'h08);
            scan(512, 10'h0F3, 10'h30C);
            cmp(4, h, "lane marks");
            cfg(8'h00, 32'h04);
            scan(512, 10'h0F8, 10'h307);
            cmp(16, h, "frame marks");
            cfg(8'h08, 32'h00000002);
            scan(512, 10'h0F8, 10'h307);
            cmp(0, h, "ramp marks");
            wb(1'h1, 8'h08, 32'hB54A0001);
            cfg(8'h00, 32'h0C);
            scan(512, 10'h0F3, 10'h30C);
            cmp(4, h, "joint lane marks");
            cfg(8'h00, 32'h01);
            scan(256, 10'h2AA, 10'h155);
            cmp(1, h < 256, "scrambled");
        end
    endtask
    task t_sync;
        begin
            pulse(4'h3);
            repeat (10) @(posedge clk_in);
            cmp(2, link_state_out, "short pulse");
            wb(1'h1, 8'h00, 32'h61);
            pulse(4'h4);
            wait_st(2'h0, 8);
            scan(8, 10'h0FA, 10'h305);
            cmp(8, h, "commas");
            t = 0;
            while (link_state_out !== 2'h1 && t < 700) begin
                @(posedge clk_in);
                t = t + 1;
            end
            cmp(1, t >= 360 && t <= 516, "release delay");
            scan(2, 10'h0F4, 10'h30B);
            cmp(1, h, "sequence start");
            scan(510, 10'h0F3, 10'h30C);
            cmp(4, h, "sequence marks");
            wait_st(2'h2, 20);
        end
    endtask
    task t_swreq;
        begin
            wb(1'h1, 8'h00, 32'h10);
            wait_st(2'h0, 8);
            scan(8, 10'h0FA, 10'h305);
            cmp(8, h, "soft commas");
            wb(1'h1, 8'h00, 32'h02);
            h = 0;
            for (i = 0; i < 300 && link_state_out !== 2'h2; i = i + 1) begin
                @(posedge clk_in);
                if (link_state_out === 2'h1) h = 1;
            end
            cmp(0, h, "sequence skipped");
            cmp(2, link_state_out, "data state");
            wb(1'h0, 8'h0C, 32'h0);
            cmp(32'h00000006, q, "status");
        end
    endtask
    task tally_and_finish;
        begin
            if (n_errors == 0 && cmp_count > 0) begin
                $display("Result: passed");
            end else begin
                $display("Result: failed");
            end
            $finish;
        end
    endtask
    // ==========================================================
    // Clock, sequence and watchdog
    initial begin
        clk_in = 1'h0;
        forever #25 clk_in = ~clk_in;
    end
    initial begin
        {rst_n_in, wb_cyc_in, wb_stb_in, wb_we_in, go} = 5'h0;
        wb_adr_in = 8'h0;
        wb_dat_in = 32'h0;
        sample_data_in = 128'h0;
        len = 4'h0;
        n_errors = 0;
        cmp_count = 0;
        repeat (12) @(posedge clk_in);
        rst_n_in <= 1'h1;
        t_regs;
        wait_st(2'h2, 1200);
        t_data;
        t_align;
        t_sync;
        t_swreq;
        tally_and_finish;
    end
    // The planned run is under ten thousand cycles; this cuts a hang.
    initial begin
        #(50 * 20000);
        n_errors = n_errors + 1;
        tally_and_finish;
    end
endmodule
